// ---- design/pitb_params.svh ----
/*
 * Register map, field positions, reset values and time base constants
 * for the interrupt request and time base block.
 * Assumes inclusion by bare name from every design file that needs it.
 */
`ifndef PITB_PARAMS_SVH
`define PITB_PARAMS_SVH

`define PITB_ADDR_W 8
`define PITB_OFS_PSC0 8'h00
`define PITB_OFS_PSC1 8'h04
`define PITB_OFS_TIME_BASE0_CONTROL 8'h08
`define PITB_OFS_TIME_BASE1_CONTROL 8'h0c
`define PITB_OFS_IRQ_CTRL 8'h10
`define PITB_OFS_IRQ_FLAGS 8'h14
`define PITB_OFS_GRP_CTRL 8'h18
`define PITB_OFS_GRP_FLAGS 8'h1c

`define PITB_RST_BYTE 8'h00
`define PITB_RD_ZERO 32'h0000_0000

// Prescaler select and time base control fields
`define PITB_PSC_MSB 1
`define PITB_TB_RUN_BIT 7
`define PITB_TB_PER_MSB 2
`define PITB_PSC_MASK 8'h03
`define PITB_TB_MASK 8'h87
`define PITB_SRC_SYS 2'h0
`define PITB_SRC_DIV4 2'h1
`define PITB_DIV4_LAST 2'h3
`define PITB_TB_CNT_W 15
`define PITB_TB_FULL_MASK 15'h7fff
`define PITB_PER_MAX 3'h7

// Core control bits
`define PITB_GIE_BIT 0
`define PITB_CONV_EN_BIT 1
`define PITB_TICK0_EN_BIT 2
`define PITB_TICK1_EN_BIT 3
`define PITB_IRQ_CTRL_MASK 8'h0f
// Core flag bits
`define PITB_CONV_F_BIT 0
`define PITB_TICK0_F_BIT 1
`define PITB_TICK1_F_BIT 2
`define PITB_IRQ_FLAGS_MASK 8'h07
// Group sources and groups, same positions in control and flag registers
`define PITB_TMA_BIT 0
`define PITB_TMP_BIT 1
`define PITB_LVS_BIT 2
`define PITB_NVW_BIT 3
`define PITB_GRP0_BIT 4
`define PITB_GRP1_BIT 5
`define PITB_GRP_MASK 8'h3f

`endif

// ---- design/pitb_pkg.sv ----
/*
 * Types shared by the interrupt request and time base block.
 * Assumes the params header is on the include path.
 */
`include "pitb_params.svh"

package pitb_pkg;
    typedef enum logic [2:0] {
        PITB_VEC_CONV = 3'h0,
        PITB_VEC_TICK0 = 3'h1,
        PITB_VEC_TICK1 = 3'h2,
        PITB_VEC_GRP0 = 3'h3,
        PITB_VEC_GRP1 = 3'h4
    } pitb_vec_t;
endpackage

// ---- design/pitb_tick_gen.sv ----
/*
 * One time base: prescaler source choice and a programmable overflow divider.
 * Assumes sub_tick is a one-cycle pulse synchronous to clk at the sub clock rate.
 */
`timescale 1ns/1ps
`include "pitb_params.svh"

module pitb_tick_gen (
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] src_sel,
    input wire logic run,
    input wire logic [2:0] period_sel,
    input wire logic sub_tick,
    output logic overflow
);
    import pitb_pkg::*;

    logic [1:0] div_reg;
    logic [`PITB_TB_CNT_W-1:0] cnt_reg;
    logic [`PITB_TB_CNT_W-1:0] mask;
    logic clk_en;

    // Free-running quarter-rate divider, shared by nothing else
    always_ff @(posedge clk)
    begin
        if (rst)
            div_reg <= 2'h0;
        else
            div_reg <= div_reg + 2'h1;
    end

    always_comb
    begin
        unique case (src_sel)
            `PITB_SRC_SYS: clk_en = 1'b1;
            `PITB_SRC_DIV4: clk_en = (div_reg == `PITB_DIV4_LAST);
            default: clk_en = sub_tick;
        endcase
    end

    // Period of 2^(8+sel) prescaler clocks
    assign mask = `PITB_TB_FULL_MASK >> (`PITB_PER_MAX - period_sel);
    assign overflow = run && clk_en && ((cnt_reg & mask) == mask);

    // Stopping clears the count so a restart always gives a full first period
    always_ff @(posedge clk)
    begin
        if (rst || !run)
            cnt_reg <= '0;
        else if (clk_en)
            cnt_reg <= overflow ? '0 : cnt_reg + 1'b1;
    end

    a_tick_stop: assert property (@(posedge clk) disable iff (rst) !run |=> cnt_reg == '0 && !overflow)
        else $error("time base count kept or overflowed while stopped");
    a_tick_count: assert property (@(posedge clk) disable iff (rst)
        overflow |-> (cnt_reg == mask) && ($past(run) || cnt_reg == '0))
        else $error("time base overflow at wrong count");
endmodule

// ---- design/pitb_top.sv ----
/*
 * Interrupt request logic with two time bases, APB register slave.
 * Assumes APB master per AMBA, sources give one-cycle pulses (low supply may be a level),
 * and the core pulses IRQ_ACK when it takes the offered vector and RETURN_FROM_IRQ_DONE on a return-from-interrupt.
 */
//
// Contract
// - Conversion done sets the conversion flag.
// - Conversion vector needs global and conversion enables, flag, stack not full.
// - Servicing conversion clears its flag and the global enable.
// - Each time base overflow sets its tick flag.
// - Tick vector needs global and tick enables, flag, stack not full.
// - Servicing a tick clears its flag and the global enable.
// - Prescaler 0 source: 00 system, 01 system/4, 1x sub clock.
// - Prescaler 1 source chosen the same way.
// - Time base 0 control bit 7 runs it; resets to zero.
// - Time base 0 period is 2^(8+field) prescaler 0 clocks.
// - Time base 1 control bit 7 runs it; resets to zero.
// - Time base 1 period is 2^(8+field) prescaler 1 clocks.
// - Unimplemented select and control bits read zero.
// - Timer module has compare A and P flags with own enables.
// - Timer vector needs global, timer, group enables, flag, stack not full.
// - Timer service clears only group flag and global enable.
// - Low supply sets its flag; vectors via group with three enables.
// - Write done sets its flag; vectors via group with three enables.
// - A group flag sets when any included source flag becomes set.
// - Return-from-interrupt sets the global enable; plain return does not.
// - Any flag rising gives a wake pulse regardless of enables.
`timescale 1ns/1ps
`include "pitb_params.svh"

module pitb_top (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [`PITB_ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic ADC_DONE,
    input wire logic TM_A_MATCH,
    input wire logic TM_P_MATCH,
    input wire logic LOW_SUPPLY,
    input wire logic NV_WRITE_DONE,
    input wire logic SUB_CLK_TICK,
    input wire logic STACK_FULL,
    input wire logic IRQ_ACK,
    input wire logic RETURN_FROM_IRQ_DONE,
    output logic IRQ_REQ,
    output pitb_pkg::pitb_vec_t IRQ_VECTOR,
    output logic WAKE
);
    import pitb_pkg::*;

    logic [7:0] psc0_reg;
    logic [7:0] psc1_reg;
    logic [7:0] time_base0_control_reg;
    logic [7:0] time_base1_control_reg;
    logic [7:0] irq_ctrl_reg;
    logic [7:0] irq_flags_reg;
    logic [7:0] irq_flags_next;
    logic [7:0] grp_ctrl_reg;
    logic [7:0] grp_flags_reg;
    logic [7:0] grp_flags_next;
    logic [31:0] prdata_reg;
    logic [31:0] rd_data;
    logic pslverr_reg;
    logic rd_hit;
    logic wr_en;
    logic setup;
    logic tick0_ovf;
    logic tick1_ovf;
    logic [7:0] src_set;
    logic [7:0] grp_set;
    logic serve;
    logic req_reg;
    logic req_next;
    pitb_vec_t vec_reg;
    pitb_vec_t vec_next;
    logic wake_reg;
    logic gie_next;

    assign setup = PSEL && !PENABLE;
    assign wr_en = PSEL && PENABLE && PWRITE;
    assign serve = IRQ_ACK && req_reg;

    // Time bases
    pitb_tick_gen u_tick0 (
        .clk(MCLK),
        .rst(RST),
        .src_sel(psc0_reg[`PITB_PSC_MSB:0]),
        .run(time_base0_control_reg[`PITB_TB_RUN_BIT]),
        .period_sel(time_base0_control_reg[`PITB_TB_PER_MSB:0]),
        .sub_tick(SUB_CLK_TICK),
        .overflow(tick0_ovf)
    );

    pitb_tick_gen u_tick1 (
        .clk(MCLK),
        .rst(RST),
        .src_sel(psc1_reg[`PITB_PSC_MSB:0]),
        .run(time_base1_control_reg[`PITB_TB_RUN_BIT]),
        .period_sel(time_base1_control_reg[`PITB_TB_PER_MSB:0]),
        .sub_tick(SUB_CLK_TICK),
        .overflow(tick1_ovf)
    );

    // Configuration registers; unimplemented bits never store
    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            psc0_reg <= `PITB_RST_BYTE;
            psc1_reg <= `PITB_RST_BYTE;
            time_base0_control_reg <= `PITB_RST_BYTE;
            time_base1_control_reg <= `PITB_RST_BYTE;
            grp_ctrl_reg <= `PITB_RST_BYTE;
        end
        else if (wr_en)
        begin
            unique case (PADDR)
                `PITB_OFS_PSC0: psc0_reg <= PWDATA[7:0] & `PITB_PSC_MASK;
                `PITB_OFS_PSC1: psc1_reg <= PWDATA[7:0] & `PITB_PSC_MASK;
                `PITB_OFS_TIME_BASE0_CONTROL: time_base0_control_reg <= PWDATA[7:0] & `PITB_TB_MASK;
                `PITB_OFS_TIME_BASE1_CONTROL: time_base1_control_reg <= PWDATA[7:0] & `PITB_TB_MASK;
                `PITB_OFS_GRP_CTRL: grp_ctrl_reg <= PWDATA[7:0] & `PITB_GRP_MASK;
                default: ;
            endcase
        end
    end

    // Global enable: service clears it, return-from-interrupt sets it
    always_comb
    begin
        gie_next = irq_ctrl_reg[`PITB_GIE_BIT];
        if (wr_en && PADDR == `PITB_OFS_IRQ_CTRL)
            gie_next = PWDATA[`PITB_GIE_BIT];
        if (serve)
            gie_next = 1'b0;
        if (RETURN_FROM_IRQ_DONE)
            gie_next = 1'b1;
    end

    always_ff @(posedge MCLK)
    begin
        if (RST)
            irq_ctrl_reg <= `PITB_RST_BYTE;
        else
        begin
            if (wr_en && PADDR == `PITB_OFS_IRQ_CTRL)
                irq_ctrl_reg <= PWDATA[7:0] & `PITB_IRQ_CTRL_MASK;
            irq_ctrl_reg[`PITB_GIE_BIT] <= gie_next;
        end
    end

    // Core flags: hardware set beats both software write and service clear
    always_comb
    begin
        irq_flags_next = irq_flags_reg;
        if (wr_en && PADDR == `PITB_OFS_IRQ_FLAGS)
            irq_flags_next = PWDATA[7:0] & `PITB_IRQ_FLAGS_MASK;
        if (serve && vec_reg == PITB_VEC_CONV)
            irq_flags_next[`PITB_CONV_F_BIT] = 1'b0;
        if (serve && vec_reg == PITB_VEC_TICK0)
            irq_flags_next[`PITB_TICK0_F_BIT] = 1'b0;
        if (serve && vec_reg == PITB_VEC_TICK1)
            irq_flags_next[`PITB_TICK1_F_BIT] = 1'b0;
        if (ADC_DONE)
            irq_flags_next[`PITB_CONV_F_BIT] = 1'b1;
        if (tick0_ovf)
            irq_flags_next[`PITB_TICK0_F_BIT] = 1'b1;
        if (tick1_ovf)
            irq_flags_next[`PITB_TICK1_F_BIT] = 1'b1;
    end

    // Group sources: service never touches them, only software clears them
    always_comb
    begin
        src_set = '0;
        src_set[`PITB_TMA_BIT] = TM_A_MATCH;
        src_set[`PITB_TMP_BIT] = TM_P_MATCH;
        src_set[`PITB_LVS_BIT] = LOW_SUPPLY;
        src_set[`PITB_NVW_BIT] = NV_WRITE_DONE;
        grp_flags_next = grp_flags_reg;
        if (wr_en && PADDR == `PITB_OFS_GRP_FLAGS)
            grp_flags_next = PWDATA[7:0] & `PITB_GRP_MASK;
        if (serve && vec_reg == PITB_VEC_GRP0)
            grp_flags_next[`PITB_GRP0_BIT] = 1'b0;
        if (serve && vec_reg == PITB_VEC_GRP1)
            grp_flags_next[`PITB_GRP1_BIT] = 1'b0;
        grp_flags_next = grp_flags_next | src_set;
        // A source newly set sets its group, even against a clear of the group
        grp_set = grp_flags_next & ~grp_flags_reg;
        if (grp_set[`PITB_TMA_BIT] || grp_set[`PITB_TMP_BIT])
            grp_flags_next[`PITB_GRP0_BIT] = 1'b1;
        if (grp_set[`PITB_LVS_BIT] || grp_set[`PITB_NVW_BIT])
            grp_flags_next[`PITB_GRP1_BIT] = 1'b1;
    end

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            irq_flags_reg <= `PITB_RST_BYTE;
            grp_flags_reg <= `PITB_RST_BYTE;
        end
        else
        begin
            irq_flags_reg <= irq_flags_next;
            grp_flags_reg <= grp_flags_next;
        end
    end

    // Request arbitration in fixed priority: conversion, tick 0, tick 1, group 0, group 1
    always_comb
    begin
        req_next = 1'b0;
        vec_next = vec_reg;
        if (irq_ctrl_reg[`PITB_CONV_EN_BIT] && irq_flags_reg[`PITB_CONV_F_BIT])
        begin
            req_next = 1'b1;
            vec_next = PITB_VEC_CONV;
        end
        else if (irq_ctrl_reg[`PITB_TICK0_EN_BIT] && irq_flags_reg[`PITB_TICK0_F_BIT])
        begin
            req_next = 1'b1;
            vec_next = PITB_VEC_TICK0;
        end
        else if (irq_ctrl_reg[`PITB_TICK1_EN_BIT] && irq_flags_reg[`PITB_TICK1_F_BIT])
        begin
            req_next = 1'b1;
            vec_next = PITB_VEC_TICK1;
        end
        else if (grp_ctrl_reg[`PITB_GRP0_BIT] && grp_flags_reg[`PITB_GRP0_BIT] &&
                 ((grp_ctrl_reg[`PITB_TMA_BIT] && grp_flags_reg[`PITB_TMA_BIT]) ||
                  (grp_ctrl_reg[`PITB_TMP_BIT] && grp_flags_reg[`PITB_TMP_BIT])))
        begin
            req_next = 1'b1;
            vec_next = PITB_VEC_GRP0;
        end
        else if (grp_ctrl_reg[`PITB_GRP1_BIT] && grp_flags_reg[`PITB_GRP1_BIT] &&
                 ((grp_ctrl_reg[`PITB_LVS_BIT] && grp_flags_reg[`PITB_LVS_BIT]) ||
                  (grp_ctrl_reg[`PITB_NVW_BIT] && grp_flags_reg[`PITB_NVW_BIT])))
        begin
            req_next = 1'b1;
            vec_next = PITB_VEC_GRP1;
        end
        // A full stack or a cleared global enable holds every request back
        if (!irq_ctrl_reg[`PITB_GIE_BIT] || STACK_FULL || serve)
            req_next = 1'b0;
    end

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            req_reg <= 1'b0;
            vec_reg <= PITB_VEC_CONV;
        end
        else
        begin
            req_reg <= req_next;
            vec_reg <= vec_next;
        end
    end

    // Wake on any rising flag, independent of enables
    always_ff @(posedge MCLK)
    begin
        if (RST)
            wake_reg <= 1'b0;
        else
            wake_reg <= |(irq_flags_next & ~irq_flags_reg) || |(grp_flags_next & ~grp_flags_reg);
    end

    // APB read data captured in setup so it comes from a flop during access
    always_comb
    begin
        rd_data = `PITB_RD_ZERO;
        rd_hit = 1'b1;
        unique case (PADDR)
            `PITB_OFS_PSC0: rd_data[7:0] = psc0_reg;
            `PITB_OFS_PSC1: rd_data[7:0] = psc1_reg;
            `PITB_OFS_TIME_BASE0_CONTROL: rd_data[7:0] = time_base0_control_reg;
            `PITB_OFS_TIME_BASE1_CONTROL: rd_data[7:0] = time_base1_control_reg;
            `PITB_OFS_IRQ_CTRL: rd_data[7:0] = irq_ctrl_reg;
            `PITB_OFS_IRQ_FLAGS: rd_data[7:0] = irq_flags_reg;
            `PITB_OFS_GRP_CTRL: rd_data[7:0] = grp_ctrl_reg;
            `PITB_OFS_GRP_FLAGS: rd_data[7:0] = grp_flags_reg;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            prdata_reg <= `PITB_RD_ZERO;
            pslverr_reg <= 1'b0;
        end
        else if (setup)
        begin
            prdata_reg <= PWRITE ? `PITB_RD_ZERO : rd_data;
            pslverr_reg <= !rd_hit;
        end
    end

    assign PREADY = 1'b1;
    assign PRDATA = prdata_reg;
    assign PSLVERR = pslverr_reg && PSEL && PENABLE;
    assign IRQ_REQ = req_reg;
    assign IRQ_VECTOR = vec_reg;
    assign WAKE = wake_reg;

    a_conv_set: assert property (@(posedge MCLK) disable iff (RST)
        ADC_DONE |=> irq_flags_reg[`PITB_CONV_F_BIT])
        else $error("conversion done did not set its flag");
    a_conv_gate: assert property (@(posedge MCLK) disable iff (RST)
        IRQ_REQ && IRQ_VECTOR == PITB_VEC_CONV |-> $past(irq_ctrl_reg[`PITB_GIE_BIT]) &&
        $past(irq_ctrl_reg[`PITB_CONV_EN_BIT]) && $past(irq_flags_reg[`PITB_CONV_F_BIT]) && !$past(STACK_FULL))
        else $error("conversion request without its conditions");
    a_conv_serve: assert property (@(posedge MCLK) disable iff (RST)
        serve && vec_reg == PITB_VEC_CONV && !ADC_DONE && !wr_en && !RETURN_FROM_IRQ_DONE
        |=> !irq_flags_reg[`PITB_CONV_F_BIT] && !irq_ctrl_reg[`PITB_GIE_BIT] && !IRQ_REQ)
        else $error("conversion service did not clear flag and global enable");
    a_tick_set: assert property (@(posedge MCLK) disable iff (RST)
        tick0_ovf |=> irq_flags_reg[`PITB_TICK0_F_BIT])
        else $error("tick 0 overflow did not set its flag");
    a_stack_block: assert property (@(posedge MCLK) disable iff (RST) STACK_FULL |=> !IRQ_REQ)
        else $error("request offered while stack full");
    a_grp_keep: assert property (@(posedge MCLK) disable iff (RST)
        serve && vec_reg == PITB_VEC_GRP0 && !wr_en |=>
        $stable(grp_flags_reg[`PITB_TMP_BIT:`PITB_TMA_BIT]) || $rose(grp_flags_reg[`PITB_TMA_BIT]) ||
        $rose(grp_flags_reg[`PITB_TMP_BIT]))
        else $error("group service changed a source flag");
    a_grp_set: assert property (@(posedge MCLK) disable iff (RST)
        $rose(grp_flags_reg[`PITB_LVS_BIT]) |-> grp_flags_reg[`PITB_GRP1_BIT])
        else $error("low supply flag did not set its group");
    a_return_from_irq_gie: assert property (@(posedge MCLK) disable iff (RST) RETURN_FROM_IRQ_DONE |=> irq_ctrl_reg[`PITB_GIE_BIT])
        else $error("return-from-interrupt did not set the global enable");
    a_wake_rise: assert property (@(posedge MCLK) disable iff (RST)
        $rose(irq_flags_reg[`PITB_TICK1_F_BIT]) |-> WAKE)
        else $error("rising flag gave no wake");
    a_rsvd_zero: assert property (@(posedge MCLK) disable iff (RST)
        PSEL && PENABLE && !PWRITE && PADDR == `PITB_OFS_TIME_BASE0_CONTROL |-> PRDATA[6:3] == 4'h0)
        else $error("unimplemented bits read nonzero");
    a_prio_conv: assert property (@(posedge MCLK) disable iff (RST)
        IRQ_REQ && $past(irq_ctrl_reg[`PITB_CONV_EN_BIT] && irq_flags_reg[`PITB_CONV_F_BIT])
        |-> IRQ_VECTOR == PITB_VEC_CONV)
        else $error("priority order broken");
endmodule

// ---- dv/pitb_core_model.sv ----
/*
 * Behavioural core: takes offered vectors, keeps a one-level return stack,
 * returns by command or on its own. Assumes the block's registered request.
 */
`timescale 1ns/1ps

module pitb_core_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic irq_req,
    input wire pitb_pkg::pitb_vec_t irq_vec,
    input wire logic auto_ret,
    input wire logic ret_cmd,
    output logic irq_ack,
    output logic return_from_irq_done,
    output logic stack_full
);
    import pitb_pkg::*;
    int depth;
    pitb_vec_t vec_q[$];

    // One return level only, so nesting is always refused by a full stack
    assign stack_full = (depth >= 1);

    always @(posedge clk)
    begin
        if (rst)
        begin
            irq_ack <= 1'b0;
            return_from_irq_done <= 1'b0;
            depth <= 0;
        end
        else
        begin
            // Random answer delay: sometimes prompt, sometimes slow
            irq_ack <= irq_req && !irq_ack && ($urandom_range(1, 0) == 1);
            return_from_irq_done <= 1'b0;
            if (irq_ack && irq_req)
            begin
                vec_q.push_back(irq_vec);
                depth <= depth + 1;
            end
            else if (depth > 0 && !return_from_irq_done && (ret_cmd || auto_ret))
            begin
                return_from_irq_done <= 1'b1;
                depth <= depth - 1;
            end
        end
    end
endmodule

// ---- dv/periph_interrupt_and_time_base_test.sv ----
/*
 * Self-checking bench for the interrupt request and time base block.
 * Assumes the design files and the core model are compiled before it.
 */
`timescale 1ns/1ps
`include "pitb_params.svh"

module periph_interrupt_and_time_base_test;
    import pitb_pkg::*;
    logic mclk, rst, psel, pen, pwr, auto_ret, ret_cmd;
    logic sub_tick = 1'b0;
    logic ack, return_from_irq, full, req, wake, rdy, serr, e;
    logic [7:0] paddr;
    logic [31:0] pwd, prd, rd, wd;
    logic [4:0] src;
    pitb_vec_t vec;
    pitb_vec_t exp_q[$];
    int failures = 0;
    int n_compared = 0;
    int cyc = 0;
    int kw, t1, t2;
    int ctb[7] = '{0, 0, 0, 1, 1, 1, 0};
    int csrc[7] = '{0, 1, 2, 3, 0, 1, 0};
    int cper[7] = '{0, 1, 0, 0, 2, 0, 6};

    pitb_top i_dut (.MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
        .PWDATA(pwd), .PRDATA(prd), .PREADY(rdy), .PSLVERR(serr), .ADC_DONE(src[0]), .TM_A_MATCH(src[1]),
        .TM_P_MATCH(src[2]), .LOW_SUPPLY(src[3]), .NV_WRITE_DONE(src[4]), .SUB_CLK_TICK(sub_tick),
        .STACK_FULL(full), .IRQ_ACK(ack), .RETURN_FROM_IRQ_DONE(return_from_irq), .IRQ_REQ(req), .IRQ_VECTOR(vec), .WAKE(wake));
    pitb_core_model i_core (.clk(mclk), .rst(rst), .irq_req(req), .irq_vec(vec), .auto_ret(auto_ret),
        .ret_cmd(ret_cmd), .irq_ack(ack), .return_from_irq_done(return_from_irq), .stack_full(full));

    task automatic end_sim();
        $display("Compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge mclk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge mclk);
        pen <= 1'b1;
        k = 0;
        do
        begin
            @(posedge mclk);
            k++;
        end
        while (rdy !== 1'b1 && k < 50);
        rd = prd;
        e = serr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic waitn(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic pulse(input logic [4:0] m);
        @(posedge mclk);
        src <= m;
        @(posedge mclk);
        src <= '0;
    endtask

    task automatic ret_pulse();
        @(posedge mclk);
        ret_cmd <= 1'b1;
        @(posedge mclk);
        ret_cmd <= 1'b0;
    endtask

    task automatic wait_wake(output int k, output int t);
        k = 0;
        do
        begin
            @(posedge mclk);
            k++;
        end
        while (wake !== 1'b1 && k < 40000);
        t = cyc;
    endtask

    task automatic chk_vecs();
        int k;
        k = 0;
        while (i_core.vec_q.size() < exp_q.size() && k < 500)
        begin
            @(posedge mclk);
            k++;
        end
        chk(i_core.vec_q.size(), exp_q.size());
        while (exp_q.size() > 0 && i_core.vec_q.size() > 0)
            chk(i_core.vec_q.pop_front(), exp_q.pop_front());
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // Sub clock stand-in: one tick every 8 system clocks
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        sub_tick <= (cyc % 8 == 7);
    end

    // Whole run needs about 56k cycles; 90k stops a hang and stays under the cycle budget
    initial
    begin
        #2250000;
        failures++;
        end_sim();
    end

    initial
    begin
        {psel, pen, pwr, auto_ret, ret_cmd} = '0;
        paddr = '0;
        pwd = '0;
        src = '0;
        rst = 1'b1;
        wd = $urandom(32'h835c);
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            apb(0, 8'(i * 4), '0);
            chk(rd, '0);
            wd = $urandom;
            apb(1, 8'(i * 4), wd);
            apb(0, 8'(i * 4), '0);
            chk(rd, wd & ((i < 2) ? 32'h0000_0003 : 32'h0000_0087));
            apb(1, 8'(i * 4), '0);
        end
        apb(0, 8'h20, '0);
        chk(e, 1'b1);
        chk(rd, '0);
        apb(1, `PITB_OFS_IRQ_CTRL, 32'h0000_0003);
        pulse(5'h01);
        wait_wake(kw, t1);
        chk(kw, 1);
        exp_q.push_back(PITB_VEC_CONV);
        chk_vecs();
        apb(0, `PITB_OFS_IRQ_FLAGS, '0);
        chk(rd, '0);
        apb(0, `PITB_OFS_IRQ_CTRL, '0);
        chk(rd, 32'h0000_0002);
        // Software re-enables while the stack is still full
        apb(1, `PITB_OFS_IRQ_CTRL, 32'h0000_0003);
        pulse(5'h01);
        waitn(10);
        chk(i_core.vec_q.size(), '0);
        chk(req, 1'b0);
        apb(0, `PITB_OFS_IRQ_FLAGS, '0);
        chk(rd, 32'h0000_0001);
        ret_pulse();
        exp_q.push_back(PITB_VEC_CONV);
        chk_vecs();
        ret_pulse();
        waitn(3);
        apb(0, `PITB_OFS_IRQ_CTRL, '0);
        chk(rd, 32'h0000_0003);
        auto_ret <= 1'b1;
        apb(1, `PITB_OFS_IRQ_CTRL, 32'h0000_0002);
        apb(1, `PITB_OFS_GRP_CTRL, 32'h0000_003f);
        pulse(5'h1f);
        apb(1, `PITB_OFS_IRQ_CTRL, 32'h0000_0003);
        exp_q.push_back(PITB_VEC_CONV);
        exp_q.push_back(PITB_VEC_GRP0);
        exp_q.push_back(PITB_VEC_GRP1);
        chk_vecs();
        apb(0, `PITB_OFS_GRP_FLAGS, '0);
        chk(rd, 32'h0000_000f);
        apb(1, `PITB_OFS_GRP_FLAGS, '0);
        for (int s = 1; s < 5; s++)
        begin
            pulse(5'(1 << s));
            exp_q.push_back((s < 3) ? PITB_VEC_GRP0 : PITB_VEC_GRP1);
            chk_vecs();
            apb(0, `PITB_OFS_GRP_FLAGS, '0);
            chk(rd, 32'(1 << (s - 1)));
            apb(1, `PITB_OFS_GRP_FLAGS, '0);
        end
        apb(1, `PITB_OFS_GRP_CTRL, 32'h0000_000f);
        pulse(5'h02);
        waitn(10);
        chk(i_core.vec_q.size(), '0);
        apb(0, `PITB_OFS_GRP_FLAGS, '0);
        chk(rd, 32'h0000_0011);
        apb(1, `PITB_OFS_GRP_FLAGS, '0);
        apb(1, `PITB_OFS_GRP_CTRL, '0);
        apb(1, `PITB_OFS_IRQ_CTRL, 32'h0000_000d);
        for (int c = 0; c < 7; c++)
        begin
            apb(1, 8'(ctb[c] * 4), 32'(csrc[c]));
            apb(1, 8'(8 + ctb[c] * 4), 32'(8'h80 + cper[c]));
            wait_wake(kw, t1);
            wait_wake(kw, t2);
            chk(t2 - t1, (1 << (8 + cper[c])) * (csrc[c] == 0 ? 1 : csrc[c] == 1 ? 4 : 8));
            apb(1, 8'(8 + ctb[c] * 4), '0);
            waitn(20);
            while (i_core.vec_q.size() > 0)
                chk(i_core.vec_q.pop_front(), ctb[c] ? PITB_VEC_TICK1 : PITB_VEC_TICK0);
            waitn(600);
            chk(i_core.vec_q.size(), '0);
        end
        end_sim();
    end
endmodule
